// ==== verilog/fmrpc_top.sv ====
// command-level mode, reset and power-down control of a serial flash
// assumes host pins arrive asynchronously; engine status is on I_CLK_SYS
//
// Overview of operation
// R01: exit opcode in four-wire mode returns the device to serial decoding.
// R02: leaving four-wire mode keeps write latch, suspend and wrap settings.
// R03: accepted reset aborts the engine and clears all volatile settings.
// R04: reset-enable and reset are accepted in serial and four-wire modes.
// R05: reset only when reset directly follows reset-enable; others disarm.
// R06: after reset no command is accepted for the recovery time.
// R07: host should avoid resetting while program, erase or suspend is active.
// R08: in deep sleep every command is ignored.
// R09: deep sleep entry is its opcode shifted on rising clock edges.
// R10: bits after the entry opcode are dropped; entry follows chip select rise.
// R11: entry needs the full opcode and a whole-byte chip select rise.
// R12: the device starts in standby, never in deep sleep.
// R13: entry opcode is ignored while the engine is busy.
// R14: host wakes the device with a long enough chip select low pulse.
// R15: a dummy byte inside the wake pulse is ignored.
// R16: after the wake pulse standby is reached within the exit time.
// R17: a transaction started before standby is back is ignored.
// R18: enter four-wire opcode is ignored unless the quad enable bit is set.
// R19: the armed reset-enable state is cleared at power-up and after reset.
`timescale 1ns/100ps
`include "fmrpc_consts.svh"

module fmrpc_top #(
    parameter int RESET_CYC = `FMRPC_RESET_REC_CYC,
    parameter int WAKE_CYC  = `FMRPC_WAKE_LOW_CYC,
    parameter int EXIT_CYC  = `FMRPC_SLEEP_EXIT_CYC
) (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RST_N,
    input  wire logic       I_CS_N,
    input  wire logic       I_SCLK,
    input  wire logic [3:0] I_DQ,
    input  wire logic       I_ENGINE_BUSY,
    input  wire logic       I_QUAD_ENABLE,
    output logic            O_FOUR_WIRE_MODE,
    output logic            O_ENGINE_ABORT,
    output logic            O_VOLATILE_CLEAR,
    output logic            O_CMD_STROBE,
    output logic [7:0]      O_CMD_CODE,
    output logic            O_RESET_BUSY,
    output logic            O_DEEP_SLEEP,
    output logic            O_STANDBY
);

    localparam int CW = `FMRPC_CNT_W;

    // refuse counts the counter cannot hold
    initial begin
        if (RESET_CYC < 1 || RESET_CYC >= (1 << CW) ||
            WAKE_CYC < 1 || WAKE_CYC >= (1 << CW) ||
            EXIT_CYC < 1 || EXIT_CYC >= (1 << CW)) begin
            $error("fmrpc_top: cycle count out of range");
        end
    end

    localparam logic [CW-1:0] RESET_LAST = CW'(RESET_CYC - 1);
    localparam logic [CW-1:0] WAKE_MIN   = CW'(WAKE_CYC);
    localparam logic [CW-1:0] EXIT_LAST  = CW'(EXIT_CYC - 1);
    localparam logic [CW-1:0] CNT_MAX    = {CW{1'b1}};

    // pin synchroniser stages
    fmrpc_pkg::fmrpc_pins_t pin_s1_q;
    fmrpc_pkg::fmrpc_pins_t pin_s2_q;
    logic                   cs_prev_q;
    logic                   sclk_prev_q;

    // control state and its next values
    fmrpc_pkg::fmrpc_state_t state_q;
    fmrpc_pkg::fmrpc_state_t state_d;
    logic [CW-1:0]           cnt_q;
    logic [CW-1:0]           cnt_d;
    logic                    four_wire_q;
    logic                    four_wire_d;
    logic                    armed_q;
    logic                    armed_d;
    logic [7:0]              shift_q;
    logic [7:0]              shift_d;
    logic [2:0]              bits_q;
    logic [2:0]              bits_d;
    logic                    full_q;
    logic                    full_d;
    logic                    ignore_q;
    logic                    ignore_d;

    // registered outputs and their next values
    logic                    abort_q;
    logic                    abort_d;
    logic                    clear_q;
    logic                    clear_d;
    logic                    strobe_q;
    logic                    strobe_d;
    logic [7:0]              code_q;
    logic [7:0]              code_d;
    logic                    rbusy_q;
    logic                    rbusy_d;
    logic                    sleep_q;
    logic                    sleep_d;
    logic                    ready_q;
    logic                    ready_d;

    // pin events, read only from the second stage onward
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic [2:0] step;
    logic [2:0] bits_next;
    logic [7:0] shift_next;

    // two-flop synchroniser and edge history
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_s1_q    <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};
            pin_s2_q    <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q    <= '{cs_n: I_CS_N, sclk: I_SCLK, dq: I_DQ};
            pin_s2_q    <= pin_s1_q;
            cs_prev_q   <= pin_s2_q.cs_n;
            sclk_prev_q <= pin_s2_q.sclk;
        end
    end

    // edge detection on synchronised pins
    assign cs_fall   = cs_prev_q & ~pin_s2_q.cs_n;
    assign cs_rise   = ~cs_prev_q & pin_s2_q.cs_n;
    assign sclk_rise = ~sclk_prev_q & pin_s2_q.sclk & ~pin_s2_q.cs_n; // R09

    // bits per edge follow the current mode
    assign step       = four_wire_q ? `FMRPC_STEP_4W : `FMRPC_STEP_SERIAL;
    assign bits_next  = bits_q + step;
    assign shift_next = four_wire_q ? {shift_q[3:0], pin_s2_q.dq}
                                    : {shift_q[6:0], pin_s2_q.dq[0]};

    // next-state logic: framing, decode, power and recovery
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        four_wire_d = four_wire_q;
        armed_d     = armed_q;
        shift_d     = shift_q;
        bits_d      = bits_q;
        full_d      = full_q;
        ignore_d    = ignore_q;
        abort_d     = 1'b0;
        clear_d     = 1'b0;
        strobe_d    = 1'b0;
        code_d      = code_q;

        // framing of one chip select window
        if (cs_fall) begin
            bits_d   = 3'h0;
            full_d   = 1'b0;
            ignore_d = (state_q != fmrpc_pkg::ST_STANDBY); // R08 R17
        end else if (sclk_rise) begin
            bits_d = bits_next;
            if (!full_q) begin
                shift_d = shift_next;
                full_d  = (bits_next == 3'h0);
            end
            // later bits only move the bit count, opcode stays
        end

        case (state_q)
            fmrpc_pkg::ST_STANDBY: begin
                if (cs_rise && !ignore_q && full_q) begin
                    if (shift_q == `FMRPC_OP_RST_ENABLE) begin
                        armed_d = 1'b1; // R04
                    end else if (shift_q == `FMRPC_OP_RST_DEVICE && armed_q) begin
                        armed_d     = 1'b0; // R19
                        abort_d     = 1'b1; // R03
                        clear_d     = 1'b1; // R03
                        four_wire_d = 1'b0;
                        state_d     = fmrpc_pkg::ST_RESETTING; // R06
                        cnt_d       = '0;
                    end else begin
                        armed_d = 1'b0; // R05
                        if (shift_q == `FMRPC_OP_EXIT_4W && four_wire_q) begin
                            four_wire_d = 1'b0; // R01 R02
                        end else if (shift_q == `FMRPC_OP_ENTER_4W) begin
                            if (I_QUAD_ENABLE && !four_wire_q) begin
                                four_wire_d = 1'b1; // R18
                            end
                        end else if (shift_q == `FMRPC_OP_DEEP_SLEEP) begin
                            if (bits_q == 3'h0 && !I_ENGINE_BUSY) begin
                                state_d = fmrpc_pkg::ST_DEEP_SLEEP; // R10 R11 R13
                                cnt_d   = '0;
                            end
                        end else begin
                            strobe_d = 1'b1;
                            code_d   = shift_q;
                        end
                    end
                end
            end
            fmrpc_pkg::ST_RESETTING: begin
                armed_d = 1'b0;
                if (cnt_q == RESET_LAST) begin
                    state_d = fmrpc_pkg::ST_STANDBY; // R06
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            fmrpc_pkg::ST_DEEP_SLEEP: begin
                // measure the low time; bytes inside are dropped
                if (cs_fall) begin
                    cnt_d = '0; // R15
                end else if (cs_rise) begin
                    if (cnt_q >= WAKE_MIN) begin
                        state_d = fmrpc_pkg::ST_WAKING; // R14 R16
                    end
                    cnt_d = '0;
                end else if (!pin_s2_q.cs_n && cnt_q != CNT_MAX) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            fmrpc_pkg::ST_WAKING: begin
                if (cnt_q == EXIT_LAST) begin
                    state_d = fmrpc_pkg::ST_STANDBY; // R16
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = fmrpc_pkg::ST_STANDBY;
                cnt_d   = '0;
            end
        endcase

        // status outputs follow the next state
        rbusy_d = (state_d == fmrpc_pkg::ST_RESETTING);
        sleep_d = (state_d == fmrpc_pkg::ST_DEEP_SLEEP);
        ready_d = (state_d == fmrpc_pkg::ST_STANDBY);
    end

    // state registers; power-up lands in standby, serial, disarmed
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q     <= fmrpc_pkg::ST_STANDBY; // R12
            cnt_q       <= '0;
            four_wire_q <= 1'b0;
            armed_q     <= 1'b0; // R19
            shift_q     <= 8'h00;
            bits_q      <= 3'h0;
            full_q      <= 1'b0;
            ignore_q    <= 1'b0;
            abort_q     <= 1'b0;
            clear_q     <= 1'b0;
            strobe_q    <= 1'b0;
            code_q      <= 8'h00;
            rbusy_q     <= 1'b0;
            sleep_q     <= 1'b0;
            ready_q     <= 1'b1;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            four_wire_q <= four_wire_d;
            armed_q     <= armed_d;
            shift_q     <= shift_d;
            bits_q      <= bits_d;
            full_q      <= full_d;
            ignore_q    <= ignore_d;
            abort_q     <= abort_d;
            clear_q     <= clear_d;
            strobe_q    <= strobe_d;
            code_q      <= code_d;
            rbusy_q     <= rbusy_d;
            sleep_q     <= sleep_d;
            ready_q     <= ready_d;
        end
    end

    // outputs straight from flip-flops
    assign O_FOUR_WIRE_MODE = four_wire_q;
    assign O_ENGINE_ABORT   = abort_q;
    assign O_VOLATILE_CLEAR = clear_q;
    assign O_CMD_STROBE     = strobe_q;
    assign O_CMD_CODE       = code_q;
    assign O_RESET_BUSY     = rbusy_q;
    assign O_DEEP_SLEEP     = sleep_q;
    assign O_STANDBY        = ready_q;

endmodule

// ==== verilog/fmrpc_consts.svh ====
// constants of the flash mode, reset and power control block
// assumes a 20 MHz system clock; included by the package and the top module
`ifndef FMRPC_CONSTS_SVH
`define FMRPC_CONSTS_SVH

// system clock rate in MHz
`define FMRPC_CLK_MHZ        20
// opcodes handled here
`define FMRPC_OP_EXIT_4W     8'hff
`define FMRPC_OP_ENTER_4W    8'h38
`define FMRPC_OP_RST_ENABLE  8'h66
`define FMRPC_OP_RST_DEVICE  8'h99
`define FMRPC_OP_DEEP_SLEEP  8'h79
// reset_recovery_time in ns
`define FMRPC_RESET_REC_NS   28000
// wake_pulse_low_time in ns, least value
`define FMRPC_WAKE_LOW_NS    3000
// deep_sleep_exit_time in ns, longest value
`define FMRPC_SLEEP_EXIT_NS  100000
// cycle counts: least rounds up, longest rounds down
`define FMRPC_RESET_REC_CYC  ((`FMRPC_RESET_REC_NS * `FMRPC_CLK_MHZ + 999) / 1000)
`define FMRPC_WAKE_LOW_CYC   ((`FMRPC_WAKE_LOW_NS * `FMRPC_CLK_MHZ + 999) / 1000)
`define FMRPC_SLEEP_EXIT_CYC ((`FMRPC_SLEEP_EXIT_NS * `FMRPC_CLK_MHZ) / 1000)
// width of the shared cycle counter
`define FMRPC_CNT_W          12
// bits taken per clock edge in each mode
`define FMRPC_STEP_SERIAL    3'h1
`define FMRPC_STEP_4W        3'h4

`endif

// ==== verilog/fmrpc_pkg.sv ====
// types of the flash mode, reset and power control block
// assumes fmrpc_consts.svh sits beside it
`include "fmrpc_consts.svh"

package fmrpc_pkg;

    // one sample of the host pins
    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] dq;
    } fmrpc_pins_t;

    // power and recovery state
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_RESETTING,
        ST_DEEP_SLEEP,
        ST_WAKING
    } fmrpc_state_t;

endpackage

// ==== tb/fmrpc_asserts.sv ====
// checker of the reset, recovery, sleep and mode outputs
// assumes it is bound onto fmrpc_top and sees only its ports
`timescale 1ns/100ps
module fmrpc_asserts #(
    parameter int RESET_CYC = 8,
    parameter int WAKE_CYC  = 4,
    parameter int EXIT_CYC  = 8
) (
    input wire logic       I_CLK_SYS,
    input wire logic       I_RST_N,
    input wire logic       I_ENGINE_BUSY,
    input wire logic       I_QUAD_ENABLE,
    input wire logic       O_FOUR_WIRE_MODE,
    input wire logic       O_ENGINE_ABORT,
    input wire logic       O_VOLATILE_CLEAR,
    input wire logic       O_CMD_STROBE,
    input wire logic       O_RESET_BUSY,
    input wire logic       O_DEEP_SLEEP,
    input wire logic       O_STANDBY
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    logic [11:0] busy_cnt_q;
    // length of the current recovery period
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) busy_cnt_q <= 12'h000;
        else busy_cnt_q <= O_RESET_BUSY ? busy_cnt_q + 12'h001 : 12'h000;
    end
    // reset start and wake start
    sequence s_reset_go;
        O_ENGINE_ABORT && O_VOLATILE_CLEAR;
    endsequence
    sequence s_wake_go;
        $fell(O_DEEP_SLEEP);
    endsequence
    abort_with_clear_a: assert property (O_ENGINE_ABORT |-> O_VOLATILE_CLEAR &&
        O_RESET_BUSY && !O_STANDBY && !O_FOUR_WIRE_MODE) else $error("abort without clear");
    abort_one_cycle_a: assert property (s_reset_go |=> !O_ENGINE_ABORT &&
        !O_VOLATILE_CLEAR && O_RESET_BUSY) else $error("abort pulse too long");
    recovery_quiet_a: assert property (O_RESET_BUSY |-> !O_STANDBY && !O_CMD_STROBE
        && !O_DEEP_SLEEP) else $error("command taken in recovery");
    recovery_len_a: assert property ($fell(O_RESET_BUSY) |-> O_STANDBY &&
        busy_cnt_q >= RESET_CYC && busy_cnt_q <= RESET_CYC + 1) else $error("recovery length");
    sleep_quiet_a: assert property (O_DEEP_SLEEP |-> !O_STANDBY && !O_CMD_STROBE &&
        !O_ENGINE_ABORT && !O_RESET_BUSY) else $error("activity in deep sleep");
    sleep_needs_idle_a: assert property ($rose(O_DEEP_SLEEP) |->
        !$past(I_ENGINE_BUSY)) else $error("sleep entered while busy");
    quad_needs_qe_a: assert property ($rose(O_FOUR_WIRE_MODE) |->
        $past(I_QUAD_ENABLE)) else $error("four-wire mode without quad enable");
    wake_exit_a: assert property (s_wake_go |-> !O_STANDBY ##[1:1000] O_STANDBY)
        else $error("standby late after wake");
endmodule

bind fmrpc_top fmrpc_asserts #(.RESET_CYC(RESET_CYC), .WAKE_CYC(WAKE_CYC),
    .EXIT_CYC(EXIT_CYC)) u_asserts (.I_CLK_SYS, .I_RST_N, .I_ENGINE_BUSY,
    .I_QUAD_ENABLE, .O_FOUR_WIRE_MODE, .O_ENGINE_ABORT, .O_VOLATILE_CLEAR,
    .O_CMD_STROBE, .O_RESET_BUSY, .O_DEEP_SLEEP, .O_STANDBY);

// ==== tb/fmrpc_host_model.sv ====
// host controller model driving chip select, serial clock and data
// assumes the bench calls its tasks; pins change just after i_clk rises
`timescale 1ns/100ps
module fmrpc_host_model (
    input  wire logic              i_clk,
    output fmrpc_pkg::fmrpc_pins_t o_pins
);
    // idle: chip select high, clock still
    initial o_pins = '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h5};
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // units msb first, nibbles in four-wire mode, clock edges 4 cycles apart
    task automatic frame(input logic [15:0] bits, input int units, input bit w4);
        tick(1);
        o_pins.cs_n <= 1'b0;
        for (int i = 0; i < units; i++) begin
            if (w4) o_pins.dq <= bits[15-4*i -: 4];
            else o_pins.dq <= {{3{~bits[15-i]}}, bits[15-i]};
            tick(4);
            o_pins.sclk <= 1'b1;
            tick(4);
            o_pins.sclk <= 1'b0;
        end
        tick(4);
        o_pins.cs_n <= 1'b1;
        o_pins.dq <= ~o_pins.dq; // released lines flip
        tick(6);
    endtask
    // bare chip select pulse of n cycles
    task automatic pulse(input int n);
        tick(1);
        o_pins.cs_n <= 1'b0;
        tick(n);
        o_pins.cs_n <= 1'b1;
        tick(6);
    endtask
endmodule

// ==== tb/test_fmrpc_top.sv ====
// self-checking bench of fmrpc_top driven through the host model
// assumes package, design and host model are compiled first
`timescale 1ns/100ps
module test_fmrpc_top;
    typedef struct packed {
        logic [7:0] op;
        logic       qe;
        logic       w4;
        logic       fw;
        logic [7:0] code;
    } fmrpc_row_t;
    // opcode, quad enable, four-wire send, mode after, code after (00 skips)
    localparam fmrpc_row_t ROWS [8] = '{{8'h05, 3'b000, 8'h05}, {8'h38, 3'b000, 8'h00},
        {8'h38, 3'b101, 8'h00}, {8'h38, 3'b111, 8'h00}, {8'h06, 3'b111, 8'h06},
        {8'hff, 3'b110, 8'h00}, {8'hff, 3'b100, 8'hff}, {8'h99, 3'b000, 8'h99}};
    logic clk = 1'b0, rst_n = 1'b0, busy = 1'b0, qe = 1'b0;
    logic four_w, abort, vclr, stb, rbusy, sleep, stby;
    logic [7:0] code;
    fmrpc_pkg::fmrpc_pins_t pins;
    int n_fail = 0, checks_done = 0, n_vclr = 0, n_stb = 0, n_abt = 0, s;
    always #25 clk = ~clk;
    // pulse counters sampled between edges
    always @(negedge clk) begin
        if (vclr === 1'b1) n_vclr++;
        if (stb === 1'b1) n_stb++;
        if (abort === 1'b1) n_abt++;
    end
    fmrpc_host_model host (.i_clk(clk), .o_pins(pins));
    fmrpc_top #(.RESET_CYC(200), .WAKE_CYC(4), .EXIT_CYC(200)) DUT (.I_CLK_SYS(clk),
        .I_RST_N(rst_n), .I_CS_N(pins.cs_n), .I_SCLK(pins.sclk), .I_DQ(pins.dq),
        .I_ENGINE_BUSY(busy), .I_QUAD_ENABLE(qe), .O_FOUR_WIRE_MODE(four_w),
        .O_ENGINE_ABORT(abort), .O_VOLATILE_CLEAR(vclr), .O_CMD_STROBE(stb),
        .O_CMD_CODE(code), .O_RESET_BUSY(rbusy), .O_DEEP_SLEEP(sleep), .O_STANDBY(stby));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tx(input logic [7:0] op, input bit w4);
        host.frame({op, 8'h00}, w4 ? 2 : 8, w4);
        #1;
    endtask
    task automatic wait_stby();
        for (int k = 0; k < 1000 && stby !== 1'b1; k++) @(posedge clk);
        #1;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(8'(stby), 8'h01);
        check(8'(sleep), 8'h00);
        // ordinary frames from the table
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) qe <= ROWS[i].qe;
            tx(ROWS[i].op, ROWS[i].w4);
            check(8'(four_w), 8'(ROWS[i].fw));
            if (ROWS[i].code != 8'h00) check(code, ROWS[i].code);
        end
        check(n_vclr[7:0], 8'h00);
        // reset pair in four-wire mode, engine idle
        @(posedge clk) qe <= 1'b1;
        tx(8'h38, 0);
        tx(8'h66, 1);
        tx(8'h99, 1);
        check(n_vclr[7:0], 8'h01);
        check(n_abt[7:0], 8'h01);
        check(8'({rbusy, four_w}), 8'h02);
        s = n_stb;
        tx(8'h0a, 0);
        check(8'(n_stb - s), 8'h00);
        wait_stby();
        check(8'(stby), 8'h01);
        tx(8'h99, 0);
        tx(8'h66, 0);
        tx(8'h05, 0);
        tx(8'h99, 0);
        check(n_vclr[7:0], 8'h01);
        check(n_abt[7:0], 8'h01);
        check(code, 8'h99);
        // deep sleep entry
        @(posedge clk) busy <= 1'b1;
        tx(8'h79, 0);
        check(8'(sleep), 8'h00);
        @(posedge clk) busy <= 1'b0;
        host.frame(16'h79a0, 12, 0);
        #1;
        check(8'(sleep), 8'h00);
        host.frame(16'h79a5, 16, 0);
        #1;
        check(8'(sleep), 8'h01);
        s = n_stb;
        host.pulse(2);
        #1;
        check(8'(sleep), 8'h01);
        tx(8'h05, 0);
        check(8'(sleep), 8'h00);
        tx(8'h06, 0);
        check(8'(stby), 8'h00);
        check(8'(n_stb - s), 8'h00);
        wait_stby();
        tx(8'h07, 0);
        check(code, 8'h07);
        // back to four-wire so the reset has a mode to undo
        tx(8'h38, 0);
        check(8'(four_w), 8'h01);
        // second reset in mid-run
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(8'({stby, sleep, four_w}), 8'h04);
        close_out();
    end
endmodule
